// [core/cbt_buffer_ctrl.sv]
// Summary of operation
// - Mask bit one compares the identifier bit; zero makes it don't-care.
// - Thirty-two full flags in two registers, set when a message is stored.
// - Full and overflow flags clear only by writing zero; writing one keeps them.
// - Storing into an already full buffer sets its overflow flag.
// - Each control register holds an even buffer low byte, odd buffer high byte.
// - Direction bit one makes a transmit buffer, zero a receive buffer.
// - Aborted flag set on abort, stays clear after successful transmission.
// - Lost-arbitration flag set when the message loses arbitration.
// - Transmit error flag set on a bus error during sending.
// - Setting send request clears aborted, lost-arbitration and error flags.
// - Send request transmits the message and clears itself on success.
// - Writing zero to a set send request aborts the message.
// - Auto-remote enabled plus matching remote frame sets send request.
// - Auto-remote disabled leaves send request unchanged on remote frames.
// - Two-bit priority orders pending messages, three highest, zero lowest.
// - Message contents live in RAM and are moved by DMA; here o_dma writes only the filter hit code word.
// - Received messages get a five-bit filter hit code in the buffer.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cbt_buffer_ctrl
	import cbt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire cbt_bus_type i_bus,
	output logic [15:0] o_rdata,
	input wire cbt_cmp_type i_cmp,
	output logic o_eid_match,
	input wire cbt_rx_type i_rx,
	input wire cbt_txev_type i_txev,
	output cbt_tx_type o_tx,
	output logic [7:0] o_abort_req,
	output cbt_dma_type o_dma
);

	logic [7:0] ctl_reg [0:7];
	logic [7:0] ctl_next [0:7];
	logic [7:0] abort_reg;
	logic [7:0] abort_next;
	logic [31:0] full_reg;
	logic [31:0] full_next;
	logic [31:0] ovf_reg;
	logic [31:0] ovf_next;
	logic [15:0] mask_reg [0:2];
	logic [15:0] base_reg;
	logic [5:0] size_reg;
	logic [15:0] rdata_reg;
	logic eid_match_reg;
	cbt_tx_type tx_reg;
	cbt_tx_type tx_next;
	cbt_dma_type dma_reg;
	logic rx_in_area;
	logic rx_is_reply;
	logic rx_store_ok;
	logic rx_store_ovf;
	logic [31:0] rx_onehot;

	function automatic logic [15:0] buf_addr(input logic [15:0] base, input logic [4:0] idx,
		input logic [2:0] word);
		logic [15:0] offs;
		offs = 16'({idx, 3'h0}) | 16'(word);
		return 16'(base + offs);
	endfunction

	function automatic logic [15:0] clear_on_zero(input logic [15:0] old, input logic wr,
		input logic [15:0] wdata);
		return wr ? (old & wdata) : old;
	endfunction

	// Frames aimed at a transmit buffer are never stored; remote ones may be answered
	assign rx_in_area = ({1'b0, i_rx.buf_idx} < size_reg);
	assign rx_is_reply = (i_rx.buf_idx < 5'h08) &&
		ctl_reg[i_rx.buf_idx[2:0]][CBT_DIR_BIT];
	assign rx_store_ok = i_rx.store && rx_in_area && !rx_is_reply &&
		!full_reg[i_rx.buf_idx];
	assign rx_store_ovf = i_rx.store && rx_in_area && !rx_is_reply &&
		full_reg[i_rx.buf_idx];
	assign rx_onehot = 32'h0000_0001 << i_rx.buf_idx;

	// Receive flags: hardware set wins over a software clear in the same cycle
	always_comb begin
		full_next[15:0] = clear_on_zero(full_reg[15:0],
			i_bus.wr && i_bus.addr == CBT_FULL_LO_IDX, i_bus.wdata);
		full_next[31:16] = clear_on_zero(full_reg[31:16],
			i_bus.wr && i_bus.addr == CBT_FULL_HI_IDX, i_bus.wdata);
		ovf_next[15:0] = clear_on_zero(ovf_reg[15:0],
			i_bus.wr && i_bus.addr == CBT_OVF_LO_IDX, i_bus.wdata);
		ovf_next[31:16] = clear_on_zero(ovf_reg[31:16],
			i_bus.wr && i_bus.addr == CBT_OVF_HI_IDX, i_bus.wdata);
		if (rx_store_ok) begin
			full_next = full_next | rx_onehot;
		end
		if (rx_store_ovf) begin
			ovf_next = ovf_next | rx_onehot;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			full_reg <= {CBT_FLAGS_RST, CBT_FLAGS_RST};
			ovf_reg <= {CBT_FLAGS_RST, CBT_FLAGS_RST};
		end else begin
			full_reg <= full_next;
			ovf_reg <= ovf_next;
		end
	end

	// Per-buffer control: software write first, then remote and engine events
	always_comb begin
		logic wr_hit;
		logic [7:0] wb;
		logic [4:0] ctl_idx;
		wr_hit = 1'b0;
		wb = 8'h00;
		ctl_idx = 5'h00;
		for (int i = 0; i < 8; i++) begin
			ctl_next[i] = ctl_reg[i];
			abort_next[i] = abort_reg[i];
			ctl_idx = 5'(CBT_CTL01_IDX + 5'(i / 2));
			wr_hit = i_bus.wr && (i_bus.addr == ctl_idx);
			wb = (i % 2 == 1) ? i_bus.wdata[15:8] : i_bus.wdata[7:0];
			if (wr_hit) begin
				ctl_next[i][CBT_DIR_BIT] = wb[CBT_DIR_BIT];
				ctl_next[i][CBT_RTREN_BIT] = wb[CBT_RTREN_BIT];
				ctl_next[i][CBT_PRI_HI:CBT_PRI_LO] = wb[CBT_PRI_HI:CBT_PRI_LO];
				if (wb[CBT_REQ_BIT] && !ctl_reg[i][CBT_REQ_BIT]) begin
					ctl_next[i][CBT_REQ_BIT] = 1'b1;
					ctl_next[i][CBT_ABT_BIT:CBT_ERR_BIT] = 3'h0;
				end else if (!wb[CBT_REQ_BIT] && ctl_reg[i][CBT_REQ_BIT]) begin
					ctl_next[i][CBT_REQ_BIT] = 1'b0;
					abort_next[i] = 1'b1;
				end
			end
			if (i_rx.rtr && i_rx.buf_idx == 5'(i) && ctl_reg[i][CBT_DIR_BIT] &&
				ctl_reg[i][CBT_RTREN_BIT]) begin
				ctl_next[i][CBT_REQ_BIT] = 1'b1;
				ctl_next[i][CBT_ABT_BIT:CBT_ERR_BIT] = 3'h0;
			end
			if (i_txev.buf_idx == 3'(i)) begin
				if (i_txev.ok) begin
					ctl_next[i][CBT_REQ_BIT] = 1'b0;
					ctl_next[i][CBT_ABT_BIT] = 1'b0;
				end
				if (i_txev.lost) begin
					ctl_next[i][CBT_LARB_BIT] = 1'b1;
				end
				if (i_txev.err) begin
					ctl_next[i][CBT_ERR_BIT] = 1'b1;
				end
				if (i_txev.aborted) begin
					ctl_next[i][CBT_ABT_BIT] = 1'b1;
					ctl_next[i][CBT_REQ_BIT] = 1'b0;
					abort_next[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < 8; i++) begin
				ctl_reg[i] <= CBT_CTL_RST;
			end
			abort_reg <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				ctl_reg[i] <= ctl_next[i];
			end
			abort_reg <= abort_next;
		end
	end

	// Configuration registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mask_reg[0] <= CBT_MASK_RST;
			mask_reg[1] <= CBT_MASK_RST;
			mask_reg[2] <= CBT_MASK_RST;
			base_reg <= CBT_BASE_RST;
			size_reg <= CBT_SIZE_RST;
		end else if (i_bus.wr) begin
			unique case (i_bus.addr)
				CBT_MASK0_IDX: mask_reg[0] <= i_bus.wdata;
				CBT_MASK1_IDX: mask_reg[1] <= i_bus.wdata;
				CBT_MASK2_IDX: mask_reg[2] <= i_bus.wdata;
				CBT_AREA_BASE_IDX: base_reg <= i_bus.wdata;
				CBT_AREA_SIZE_IDX: size_reg <= (i_bus.wdata[5:0] > CBT_SIZE_RST) ?
					CBT_SIZE_RST : i_bus.wdata[5:0];
				default: ;
			endcase
		end
	end

	// Read port: data one cycle after the strobe, zero elsewhere
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= 16'h0000;
		end else if (i_bus.rd) begin
			unique case (i_bus.addr)
				CBT_MASK0_IDX: rdata_reg <= mask_reg[0];
				CBT_MASK1_IDX: rdata_reg <= mask_reg[1];
				CBT_MASK2_IDX: rdata_reg <= mask_reg[2];
				CBT_FULL_LO_IDX: rdata_reg <= full_reg[15:0];
				CBT_FULL_HI_IDX: rdata_reg <= full_reg[31:16];
				CBT_OVF_LO_IDX: rdata_reg <= ovf_reg[15:0];
				CBT_OVF_HI_IDX: rdata_reg <= ovf_reg[31:16];
				5'h08: rdata_reg <= {ctl_reg[1], ctl_reg[0]};
				5'h09: rdata_reg <= {ctl_reg[3], ctl_reg[2]};
				5'h0A: rdata_reg <= {ctl_reg[5], ctl_reg[4]};
				CBT_CTL67_IDX: rdata_reg <= {ctl_reg[7], ctl_reg[6]};
				CBT_AREA_BASE_IDX: rdata_reg <= base_reg;
				CBT_AREA_SIZE_IDX: rdata_reg <= {10'h000, size_reg};
				default: rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	// Extended identifier acceptance compare; the reserved selector never matches
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			eid_match_reg <= 1'b0;
		end else if (!i_cmp.valid || i_cmp.sel == CBT_MASK_SEL_RSVD) begin
			eid_match_reg <= 1'b0;
		end else begin
			eid_match_reg <= ((i_cmp.msg ^ i_cmp.flt) & mask_reg[i_cmp.sel]) == 16'h0000;
		end
	end

	// Pick the pending transmit buffer; ascending scan with >= favours the higher number
	always_comb begin
		logic cand;
		cand = 1'b0;
		tx_next = '0;
		for (int i = 0; i < 8; i++) begin
			cand = ctl_reg[i][CBT_DIR_BIT] && ctl_reg[i][CBT_REQ_BIT] && !abort_reg[i] &&
				(6'(i) < size_reg);
			if (cand && (!tx_next.valid ||
				ctl_reg[i][CBT_PRI_HI:CBT_PRI_LO] >= tx_next.prio)) begin
				tx_next.valid = 1'b1;
				tx_next.buf_idx = 3'(i);
				tx_next.prio = ctl_reg[i][CBT_PRI_HI:CBT_PRI_LO];
			end
		end
		tx_next.addr = buf_addr(base_reg, {2'h0, tx_next.buf_idx}, 3'h0);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_reg <= '0;
		end else begin
			tx_reg <= tx_next;
		end
	end

	// Filter hit code goes into the last word of a freshly stored buffer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dma_reg <= '0;
		end else begin
			dma_reg.wr <= rx_store_ok;
			dma_reg.addr <= buf_addr(base_reg, i_rx.buf_idx, CBT_HIT_WORD);
			dma_reg.data <= 16'({i_rx.hit, 8'h00});
		end
	end

	assign o_rdata = rdata_reg;
	assign o_eid_match = eid_match_reg;
	assign o_tx = tx_reg;
	assign o_abort_req = abort_reg;
	assign o_dma = dma_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence sw_set_req0;
		i_bus.wr && i_bus.addr == CBT_CTL01_IDX && i_bus.wdata[CBT_REQ_BIT] &&
			!ctl_reg[0][CBT_REQ_BIT] && i_txev == '0;
	endsequence

	sequence sw_abort0;
		i_bus.wr && i_bus.addr == CBT_CTL01_IDX && !i_bus.wdata[CBT_REQ_BIT] &&
			ctl_reg[0][CBT_REQ_BIT] && !(i_txev.aborted && i_txev.buf_idx == 3'h0);
	endsequence

	full_set_a: assert property (rx_store_ok |=> full_reg[$past(i_rx.buf_idx)])
		else $error("full flag not set after store");
	ovf_set_a: assert property (rx_store_ovf |=> ovf_reg[$past(i_rx.buf_idx)] &&
		!o_dma.wr) else $error("overflow flag not set");
	full_keep_a: assert property (i_bus.wr && i_bus.addr == CBT_FULL_LO_IDX &&
		i_bus.wdata == 16'hFFFF |=>
		(full_reg[15:0] & $past(full_reg[15:0])) == $past(full_reg[15:0]))
		else $error("writing ones changed full flags");
	req_clear_a: assert property (sw_set_req0 |=> ctl_reg[0][CBT_REQ_BIT] &&
		ctl_reg[0][CBT_ABT_BIT:CBT_ERR_BIT] == 3'h0) else $error("flags kept on request");
	tx_done_a: assert property (i_txev.ok && !i_txev.aborted |=>
		!ctl_reg[$past(i_txev.buf_idx)][CBT_REQ_BIT]) else $error("request kept after send");
	abort_flow_a: assert property (sw_abort0 ##1 (i_txev.aborted && i_txev.buf_idx == 3'h0)
		|=> ctl_reg[0][CBT_ABT_BIT] && !o_abort_req[0]) else $error("abort not reported");
	abort_req_a: assert property (sw_abort0 |=> o_abort_req[0] ##1
		(!o_tx.valid || o_tx.buf_idx != 3'h0)) else $error("abort not requested");
	auto_rtr_a: assert property (i_rx.rtr && i_rx.buf_idx == 5'h00 &&
		ctl_reg[0][CBT_DIR_BIT] && ctl_reg[0][CBT_RTREN_BIT] |=> ctl_reg[0][CBT_REQ_BIT])
		else $error("remote frame did not raise request");
	no_rtr_a: assert property (i_rx.rtr && i_rx.buf_idx == 5'h00 &&
		!ctl_reg[0][CBT_RTREN_BIT] && !i_bus.wr && i_txev == '0 |=>
		$stable(ctl_reg[0][CBT_REQ_BIT])) else $error("request changed without auto-remote");
	hit_code_a: assert property (rx_store_ok |=> o_dma.wr &&
		o_dma.data[12:8] == $past(i_rx.hit)) else $error("filter hit code not written");

endmodule // cbt_buffer_ctrl
`default_nettype wire

// [core/cbt_pkg.sv]
package cbt_pkg;

	// Register indices on the plain register port
	localparam logic [4:0] CBT_MASK0_IDX = 5'h00;
	localparam logic [4:0] CBT_MASK1_IDX = 5'h01;
	localparam logic [4:0] CBT_MASK2_IDX = 5'h02;
	localparam logic [4:0] CBT_FULL_LO_IDX = 5'h03;
	localparam logic [4:0] CBT_FULL_HI_IDX = 5'h04;
	localparam logic [4:0] CBT_OVF_LO_IDX = 5'h05;
	localparam logic [4:0] CBT_OVF_HI_IDX = 5'h06;
	localparam logic [4:0] CBT_CTL01_IDX = 5'h08;
	localparam logic [4:0] CBT_CTL67_IDX = 5'h0B;
	localparam logic [4:0] CBT_AREA_BASE_IDX = 5'h0C;
	localparam logic [4:0] CBT_AREA_SIZE_IDX = 5'h0D;

	// Control byte field positions, same in both halves
	localparam int CBT_DIR_BIT = 7;
	localparam int CBT_ABT_BIT = 6;
	localparam int CBT_LARB_BIT = 5;
	localparam int CBT_ERR_BIT = 4;
	localparam int CBT_REQ_BIT = 3;
	localparam int CBT_RTREN_BIT = 2;
	localparam int CBT_PRI_HI = 1;
	localparam int CBT_PRI_LO = 0;

	// Reset values
	localparam logic [15:0] CBT_FLAGS_RST = 16'h0000;
	localparam logic [7:0] CBT_CTL_RST = 8'h00;
	localparam logic [15:0] CBT_MASK_RST = 16'h0000;
	localparam logic [15:0] CBT_BASE_RST = 16'h0000;
	localparam logic [5:0] CBT_SIZE_RST = 6'h20;

	// Buffer word layout in RAM, and the reserved mask selector
	localparam int CBT_WORDS_PER_BUF = 8;
	localparam logic [2:0] CBT_HIT_WORD = 3'h7;
	localparam int CBT_HIT_LSB = 8;
	localparam logic [1:0] CBT_MASK_SEL_RSVD = 2'h3;

	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} cbt_bus_type;

	typedef struct packed {
		logic store;
		logic rtr;
		logic [4:0] buf_idx;
		logic [4:0] hit;
	} cbt_rx_type;

	typedef struct packed {
		logic ok;
		logic lost;
		logic err;
		logic aborted;
		logic [2:0] buf_idx;
	} cbt_txev_type;

	typedef struct packed {
		logic valid;
		logic [2:0] buf_idx;
		logic [1:0] prio;
		logic [15:0] addr;
	} cbt_tx_type;

	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [15:0] data;
	} cbt_dma_type;

	typedef struct packed {
		logic valid;
		logic [15:0] msg;
		logic [15:0] flt;
		logic [1:0] sel;
	} cbt_cmp_type;

endpackage

// [verif/can_buffer_status_and_tx_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module can_buffer_status_and_tx_control_tb
	import cbt_pkg::*;
;
	typedef struct packed {
		logic [1:0] sel;
		logic [15:0] msg;
		logic [15:0] flt;
		logic exp;
	} cbt_row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	cbt_bus_type bus = '0;
	cbt_cmp_type cmp = '0;
	cbt_rx_type rx = '0;
	cbt_txev_type txev;
	cbt_tx_type tx;
	cbt_dma_type dma;
	logic [15:0] rdata;
	logic match;
	logic [7:0] abort_req;
	logic eng_en = 1'b0;
	logic [1:0] eng_kind = 2'h0;
	int mismatches = 0;
	int total_checks = 0;
	cbt_row_type rows [6] = '{
		'{2'h0, 16'h1234, 16'h1234, 1'b1},
		'{2'h0, 16'h1234, 16'h1235, 1'b0},
		'{2'h1, 16'hAB3C, 16'h003F, 1'b1},
		'{2'h1, 16'h1234, 16'h1204, 1'b0},
		'{2'h2, 16'hFFFF, 16'h0000, 1'b1},
		'{2'h3, 16'h1234, 16'h1234, 1'b0}};
	always #2.5 clk = ~clk;
	cbt_buffer_ctrl i_cbt_buffer_ctrl (.i_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
		.i_cmp(cmp), .o_eid_match(match), .i_rx(rx), .i_txev(txev), .o_tx(tx),
		.o_abort_req(abort_req), .o_dma(dma));
	cbt_engine_model i_cbt_engine_model (.i_clk(clk), .i_rst(rst), .i_en(eng_en),
		.i_kind(eng_kind), .i_tx(tx), .i_abort_req(abort_req), .o_txev(txev));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic rx_ev(input logic st, input logic rt, input logic [4:0] idx);
		@(posedge clk);
		rx <= '{store: st, rtr: rt, buf_idx: idx, hit: 5'h05};
		@(posedge clk);
		rx <= '0;
		@(negedge clk);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic eng(input logic en, input logic [1:0] kind);
		@(posedge clk);
		eng_en <= en;
		eng_kind <= kind;
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Whole sequence needs well under 1000 cycles
	initial begin
		#(5 * 20000);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(CBT_FULL_LO_IDX, 16'h0000);
		rd(CBT_FULL_HI_IDX, 16'h0000);
		rd(CBT_OVF_LO_IDX, 16'h0000);
		rd(CBT_OVF_HI_IDX, 16'h0000);
		rd(5'h07, 16'h0000);
		rd(CBT_AREA_SIZE_IDX, 16'h0020);
		wr(CBT_CTL01_IDX, 16'h7070);
		rd(CBT_CTL01_IDX, 16'h0000);
		wr(CBT_MASK0_IDX, 16'hFFFF);
		wr(CBT_MASK1_IDX, 16'h00F0);
		wr(CBT_MASK2_IDX, 16'h0000);
		foreach (rows[i]) begin
			@(posedge clk);
			cmp <= '{valid: 1'b1, msg: rows[i].msg, flt: rows[i].flt, sel: rows[i].sel};
			idle(1);
			chk({15'h0000, match}, {15'h0000, rows[i].exp});
		end
		cmp <= '0;
		wr(CBT_AREA_BASE_IDX, 16'h0100);
		rx_ev(1'b1, 1'b0, 5'd3);
		chk({15'h0000, dma.wr}, 16'h0001);
		chk(dma.addr, 16'h011F);
		chk(dma.data, 16'h0500);
		rx_ev(1'b1, 1'b0, 5'd20);
		rx_ev(1'b1, 1'b0, 5'd3);
		chk({15'h0000, dma.wr}, 16'h0000);
		rd(CBT_FULL_LO_IDX, 16'h0008);
		rd(CBT_FULL_HI_IDX, 16'h0010);
		rd(CBT_OVF_LO_IDX, 16'h0008);
		wr(CBT_FULL_LO_IDX, 16'hFFFF);
		rd(CBT_FULL_LO_IDX, 16'h0008);
		wr(CBT_FULL_LO_IDX, 16'hFFF7);
		wr(CBT_FULL_HI_IDX, 16'h0000);
		rd(CBT_FULL_LO_IDX, 16'h0000);
		rd(CBT_OVF_LO_IDX, 16'h0008);
		wr(CBT_OVF_LO_IDX, 16'h0000);
		rd(CBT_OVF_LO_IDX, 16'h0000);
		wr(CBT_CTL01_IDX, 16'h8480);
		rx_ev(1'b1, 1'b0, 5'd0);
		chk({15'h0000, dma.wr}, 16'h0000);
		rx_ev(1'b0, 1'b1, 5'd1);
		rx_ev(1'b0, 1'b1, 5'd0);
		rd(CBT_CTL01_IDX, 16'h8C80);
		chk(tx.addr, 16'h0108);
		wr(CBT_CTL67_IDX, 16'h8B8B);
		idle(2);
		chk({13'h0000, tx.buf_idx}, 16'h0007);
		chk({14'h0000, tx.prio}, 16'h0003);
		chk(tx.addr, 16'h0138);
		eng(1'b1, 2'h1);
		idle(6);
		eng(1'b0, 2'h1);
		idle(4);
		rd(CBT_CTL67_IDX, 16'hAB8B);
		eng(1'b1, 2'h2);
		idle(6);
		eng(1'b0, 2'h2);
		idle(4);
		rd(CBT_CTL67_IDX, 16'hBB8B);
		wr(CBT_CTL67_IDX, 16'h838B);
		idle(4);
		rd(CBT_CTL67_IDX, 16'hF38B);
		chk({8'h00, abort_req}, 16'h0000);
		wr(CBT_CTL67_IDX, 16'h8B8B);
		rd(CBT_CTL67_IDX, 16'h8B8B);
		eng(1'b1, 2'h0);
		idle(24);
		eng(1'b0, 2'h0);
		idle(2);
		rd(CBT_CTL67_IDX, 16'h8383);
		rd(CBT_CTL01_IDX, 16'h8480);
		chk({15'h0000, tx.valid}, 16'h0000);
		wr(CBT_CTL01_IDX, 16'h8488);
		rd(CBT_CTL01_IDX, 16'h8488);
		wr(CBT_CTL01_IDX, 16'h8480);
		idle(4);
		rd(CBT_CTL01_IDX, 16'h84C0);
		chk({8'h00, abort_req}, 16'h0000);
		wr(CBT_AREA_SIZE_IDX, 16'h0004);
		rx_ev(1'b1, 1'b0, 5'd10);
		chk({15'h0000, dma.wr}, 16'h0000);
		tally_and_finish();
	end
endmodule // can_buffer_status_and_tx_control_tb
`default_nettype wire

// [verif/cbt_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cbt_engine_model
	import cbt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic [1:0] i_kind,
	input wire cbt_tx_type i_tx,
	input wire logic [7:0] i_abort_req,
	output cbt_txev_type o_txev
);
	// Four cycles per attempt, so the pending choice settles before the next one
	logic [1:0] wait_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_en || !i_tx.valid) begin
			wait_reg <= 2'h0;
		end else begin
			wait_reg <= wait_reg + 2'h1;
		end
	end
	always_ff @(posedge i_clk) begin
		o_txev <= '0;
		if (i_rst) begin
			o_txev <= '0;
		end else if (i_abort_req != 8'h00 && !o_txev.aborted) begin
			o_txev.aborted <= 1'b1;
			for (int k = 7; k >= 0; k--) begin
				if (i_abort_req[k]) begin
					o_txev.buf_idx <= 3'(k);
				end
			end
		end else if (wait_reg == 2'h3) begin
			o_txev.ok <= (i_kind == 2'h0);
			o_txev.lost <= (i_kind == 2'h1);
			o_txev.err <= (i_kind == 2'h2);
			o_txev.buf_idx <= i_tx.buf_idx;
		end
	end
endmodule // cbt_engine_model
`default_nettype wire
